// [src/bnsc_top.sv]
/*
  Network side of a breaker trip unit: address selectors, status and trip reporting,
  remote trip and close, local reset, and the carrier link on the shared pair.
  Assumes the protection logic runs on CLK; pins and the line are synchronised here.
*/
`timescale 1ns/1ps
module bnsc_top #(
  parameter int BIT_CYC = bnsc_pkg::BIT_CYC,
  parameter int COIL_CYC = bnsc_pkg::COIL_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // Address selectors and their viewing windows
  input wire logic [2:0][3:0] ADDR_SW,
  output logic [2:0][3:0] ADDR_SHOW,
  // Breaker, options, settings and pushbutton pins
  input wire logic BKR_CLOSED,
  input wire logic SPRING_OPT,
  input wire logic TRIP_RESET_B,
  input wire logic [2:0] LD_SEL,
  input wire logic [15:0] PLUG_AMPS,
  // Protection logic
  input wire logic PROT_TRIP,
  input wire logic [1:0] PROT_FN,
  input wire bnsc_pkg::bnsc_meter_s METER,
  // Breaker and panel outputs
  output logic TRIP_COIL,
  output logic CLOSE_COIL,
  output logic TRIP_FREE,
  output logic ALARM_RELAY,
  output logic [3:0] CAUSE_LED,
  // Shared pair
  input wire logic LINE_I,
  output logic LINE_O,
  output logic LINE_OE
);

  // ********************
  // Pin synchronisers
  // ********************
  localparam int PIN_W = 35;
  localparam logic [PIN_W-1:0] PIN_RST = 35'h000100000;
  localparam logic [19:0] BIT_T = 20'(BIT_CYC - 1);
  localparam logic [19:0] HALF_T = 20'(BIT_CYC / 2);
  localparam logic [19:0] CD_T = 20'(bnsc_pkg::CD_WIN);
  localparam logic [7:0] CAR_T = 8'(bnsc_pkg::HALF_CAR - 1);
  localparam logic [17:0] COIL_T = 18'(COIL_CYC - 1);
  localparam logic [5:0] RX_STOP = 6'h21;
  localparam logic [5:0] TX_LAST = 6'h1f;

  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  logic line_d;
  logic rst_btn_d;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pin_meta <= PIN_RST;
      pin_sync <= PIN_RST;
    end else begin
      pin_meta <= {ADDR_SW, BKR_CLOSED, SPRING_OPT, TRIP_RESET_B, LD_SEL, PLUG_AMPS, LINE_I};
      pin_sync <= pin_meta;
    end
  end

  wire logic [11:0] s_addr = pin_sync[34:23];
  wire logic s_closed = pin_sync[22];
  wire logic s_spring = pin_sync[21];
  wire logic s_rst_b = pin_sync[20];
  wire logic [2:0] s_ld_sel = pin_sync[19:17];
  wire logic [15:0] s_plug = pin_sync[16:1];
  wire logic s_line = pin_sync[0];
  wire logic reset_press = rst_btn_d && !s_rst_b;

  // A selector resting between detents may read above nine; it shows as nine.
  function automatic logic [3:0] digit_clamp(input logic [3:0] d);
    digit_clamp = (d > bnsc_pkg::DIGIT_MAX) ? bnsc_pkg::DIGIT_MAX : d;
  endfunction

  function automatic logic [3:0] fn_cause(input logic [1:0] fn);
    unique case (fn)
      bnsc_pkg::FN_LONG: fn_cause = bnsc_pkg::CAUSE_LONG_DELAY;
      bnsc_pkg::FN_SHORT: fn_cause = bnsc_pkg::SHORT_DELAY_TRIP_CODE;
      bnsc_pkg::FN_INST: fn_cause = bnsc_pkg::CAUSE_INSTANT;
      bnsc_pkg::FN_GROUND: fn_cause = bnsc_pkg::CAUSE_GROUND;
    endcase
  endfunction

  // ********************
  // Address windows
  // ********************
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ADDR_SHOW <= '0;
      rst_btn_d <= 1'b1;
    end else begin
      for (int i = 0; i < 3; i++) begin
        ADDR_SHOW[i] <= digit_clamp(s_addr[i*4 +: 4]);
      end
      rst_btn_d <= s_rst_b;
    end
  end

  // ********************
  // Carrier detect
  // ********************
  logic [19:0] cd_cnt;
  logic carrier_on;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      line_d <= 1'b0;
      cd_cnt <= CD_T;
      carrier_on <= 1'b0;
    end else begin
      line_d <= s_line;
      if (s_line != line_d) begin
        cd_cnt <= '0;
      end else if (cd_cnt != CD_T) begin
        cd_cnt <= cd_cnt + 20'h1;
      end
      carrier_on <= cd_cnt != CD_T;
    end
  end

  // ********************
  // Receiver
  // ********************
  bnsc_pkg::bnsc_tx_e tx_st;
  logic rx_busy;
  logic rx_done;
  logic [19:0] rx_cnt;
  logic [5:0] rx_idx;
  logic [31:0] rx_sh;

  // Bits sampled mid-cell; our own bursts are not received.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rx_busy <= 1'b0;
      rx_done <= 1'b0;
      rx_cnt <= '0;
      rx_idx <= '0;
      rx_sh <= '0;
    end else begin
      rx_done <= 1'b0;
      if (!rx_busy) begin
        // A master may start its frame during our stop bit, so reception is allowed there.
        if (carrier_on && (tx_st == bnsc_pkg::TX_IDLE || tx_st == bnsc_pkg::TX_STOP)) begin
          rx_busy <= 1'b1;
          rx_cnt <= HALF_T;
          rx_idx <= '0;
        end
      end else if (rx_cnt != '0) begin
        rx_cnt <= rx_cnt - 20'h1;
      end else begin
        rx_cnt <= BIT_T;
        rx_idx <= rx_idx + 6'h1;
        if (rx_idx == '0) begin
          rx_busy <= carrier_on;
        end else if (rx_idx == RX_STOP) begin
          rx_busy <= 1'b0;
          rx_done <= !carrier_on;
        end else begin
          rx_sh <= {carrier_on, rx_sh[31:1]};
        end
      end
    end
  end

  bnsc_pkg::bnsc_frame_s rx_frame;
  logic hit;

  always_comb begin
    rx_frame = rx_sh;
    hit = rx_done && rx_frame.addr == ADDR_SHOW;
  end

  wire logic trip_cmd = hit && rx_frame.kind == bnsc_pkg::CMD_TRIP;
  wire logic close_cmd = hit && rx_frame.kind == bnsc_pkg::CMD_CLOSE;

  // ********************
  // Trip state and local reset
  // ********************
  logic tripped;
  logic [3:0] cause;
  bnsc_pkg::bnsc_meter_s fault;
  logic close_ok;

  always_comb begin
    close_ok = s_spring && (!TRIP_FREE || cause == bnsc_pkg::EXTERNAL_TRIP_CODE);
  end

  // A trip in the same cycle as a reset press wins over the clear.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      tripped <= 1'b0;
      cause <= bnsc_pkg::CAUSE_NONE;
      fault <= '0;
      TRIP_FREE <= 1'b0;
      ALARM_RELAY <= 1'b0;
      CAUSE_LED <= '0;
    end else if (PROT_TRIP) begin
      tripped <= 1'b1;
      cause <= fn_cause(PROT_FN);
      fault <= METER;
      TRIP_FREE <= 1'b1;
      ALARM_RELAY <= 1'b1;
      CAUSE_LED[PROT_FN] <= 1'b1;
    end else if (trip_cmd) begin
      tripped <= 1'b1;
      cause <= bnsc_pkg::EXTERNAL_TRIP_CODE;
      TRIP_FREE <= 1'b1;
    end else if (reset_press) begin
      tripped <= 1'b0;
      cause <= bnsc_pkg::CAUSE_NONE;
      fault <= '0;
      TRIP_FREE <= 1'b0;
      ALARM_RELAY <= 1'b0;
      CAUSE_LED <= '0;
    end
  end

  // ********************
  // Coil drivers
  // ********************
  logic [17:0] trip_cnt;
  logic [17:0] close_cnt;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      trip_cnt <= '0;
      TRIP_COIL <= 1'b0;
    end else if (PROT_TRIP || trip_cmd) begin
      trip_cnt <= COIL_T;
      TRIP_COIL <= 1'b1;
    end else if (trip_cnt != '0) begin
      trip_cnt <= trip_cnt - 18'h1;
    end else begin
      TRIP_COIL <= 1'b0;
    end
  end

  // A trip pulse cuts a close pulse short.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      close_cnt <= '0;
      CLOSE_COIL <= 1'b0;
    end else if (PROT_TRIP || trip_cmd || TRIP_COIL) begin
      close_cnt <= '0;
      CLOSE_COIL <= 1'b0;
    end else if (close_cmd && close_ok) begin
      close_cnt <= COIL_T;
      CLOSE_COIL <= 1'b1;
    end else if (close_cnt != '0) begin
      close_cnt <= close_cnt - 18'h1;
    end else begin
      CLOSE_COIL <= 1'b0;
    end
  end

  // ********************
  // Message contents
  // ********************
  logic [3:0] tx_kind;
  logic [15:0] tx_value;
  logic [1:0] bkr_state;
  logic [20:0] pickup;
  logic auto_trip;

  always_comb begin
    bkr_state = s_closed ? bnsc_pkg::BKR_CLOSED : (tripped ? bnsc_pkg::BKR_TRIPPED : bnsc_pkg::BKR_OPEN);
    pickup = 21'(s_plug * bnsc_pkg::PICKUP_16THS[s_ld_sel]);
    auto_trip = tripped && cause != bnsc_pkg::EXTERNAL_TRIP_CODE;
    unique case (tx_kind)
      bnsc_pkg::MSG_STATUS: tx_value = {8'h00, s_spring, TRIP_FREE, cause, bkr_state};
      bnsc_pkg::MSG_CAUSE: tx_value = {12'h000, cause};
      bnsc_pkg::MSG_IA: tx_value = auto_trip ? fault.ia : METER.ia;
      bnsc_pkg::MSG_IB: tx_value = auto_trip ? fault.ib : METER.ib;
      bnsc_pkg::MSG_IC: tx_value = auto_trip ? fault.ic : METER.ic;
      bnsc_pkg::MSG_IG: tx_value = auto_trip ? fault.ig : METER.ig;
      bnsc_pkg::MSG_PEAK: tx_value = METER.peak;
      bnsc_pkg::MSG_PRESENT: tx_value = METER.present;
      bnsc_pkg::MSG_ENERGY: tx_value = METER.energy;
      bnsc_pkg::MSG_PICKUP: tx_value = pickup[19:4];
      default: tx_value = 16'h0000;
    endcase
  end

  // ********************
  // Message scheduler
  // ********************
  logic ans_pend;
  logic [3:0] rot_kind;
  logic tx_load;

  // Answers go out as a status message ahead of the rotation.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ans_pend <= 1'b0;
      rot_kind <= bnsc_pkg::MSG_STATUS;
    end else begin
      if (hit) begin
        ans_pend <= 1'b1;
      end else if (tx_load && ans_pend) begin
        ans_pend <= 1'b0;
      end
      if (PROT_TRIP) begin
        rot_kind <= bnsc_pkg::MSG_CAUSE;
      end else if (tx_load && !ans_pend) begin
        rot_kind <= (rot_kind == bnsc_pkg::MSG_PICKUP) ? bnsc_pkg::MSG_STATUS : rot_kind + 4'h1;
      end
    end
  end

  // ********************
  // Transmitter
  // ********************
  logic [19:0] tx_cnt;
  logic [5:0] tx_idx;
  logic [31:0] tx_sh;
  logic [7:0] car_cnt;
  logic car_ph;
  logic key_on;

  always_comb begin
    // Holding off until the coils settle makes an answer report the state after the command.
    tx_load = tx_st == bnsc_pkg::TX_IDLE && !rx_busy && !carrier_on && !rx_done && !TRIP_COIL && !CLOSE_COIL;
    tx_kind = ans_pend ? bnsc_pkg::MSG_STATUS : rot_kind;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_st <= bnsc_pkg::TX_IDLE;
      tx_cnt <= '0;
      tx_idx <= '0;
      tx_sh <= '0;
      key_on <= 1'b0;
    end else if (tx_load) begin
      tx_st <= bnsc_pkg::TX_START;
      tx_cnt <= BIT_T;
      tx_sh <= {tx_value, tx_kind, ADDR_SHOW};
      key_on <= 1'b1;
    end else if (tx_st != bnsc_pkg::TX_IDLE && tx_cnt != '0) begin
      tx_cnt <= tx_cnt - 20'h1;
    end else begin
      tx_cnt <= BIT_T;
      unique case (tx_st)
        bnsc_pkg::TX_IDLE: begin
          key_on <= 1'b0;
        end
        bnsc_pkg::TX_START: begin
          tx_st <= bnsc_pkg::TX_DATA;
          tx_idx <= '0;
          key_on <= tx_sh[0];
        end
        bnsc_pkg::TX_DATA: begin
          tx_sh <= {1'b0, tx_sh[31:1]};
          tx_idx <= tx_idx + 6'h1;
          if (tx_idx == TX_LAST) begin
            tx_st <= bnsc_pkg::TX_STOP;
            key_on <= 1'b0;
          end else begin
            key_on <= tx_sh[1];
          end
        end
        bnsc_pkg::TX_STOP: begin
          tx_st <= bnsc_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // Carrier of 115.2 kHz keyed by the bit value.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      car_cnt <= '0;
      car_ph <= 1'b0;
      LINE_O <= 1'b0;
      LINE_OE <= 1'b0;
    end else begin
      if (car_cnt == CAR_T) begin
        car_cnt <= '0;
        car_ph <= !car_ph;
      end else begin
        car_cnt <= car_cnt + 8'h1;
      end
      LINE_OE <= tx_st == bnsc_pkg::TX_START || tx_st == bnsc_pkg::TX_DATA;
      LINE_O <= key_on && car_ph;
    end
  end

endmodule

// [pkg/bnsc_pkg.sv]
/*
  Constants, codes and carrier types of the breaker network status and command block.
  Assumes a single 25 MHz clock and an on/off keyed carrier on one shared twisted pair.
*/
// Notes on behaviour
// - Station address is three decimal digits, one from each ten-position selector.
// - Each digit window shows the selector's current value while it turns.
// - Breaker state is reported as open, closed or tripped.
// - Remote trip always trips; remote close only with spring release option fitted.
// - Remote trips use the same trip coil output as the device's own trips.
// - A remote trip leaves the external trip code as the reported cause.
// - Any trip holds the breaker trip-free against local closing until local reset.
// - After an external trip a remote close is accepted without local reset.
// - In service the device keeps sending coded messages, phase currents included.
// - Bits are 115.2 kHz carrier bursts, at no more than 1200 bits per second.
// - Messages carry everything shown on the local display.
// - After an automatic trip, cause and per-phase or ground fault current are sent.
// - A short-delay trip is reported with the short delay trip code.
// - Cause and fault currents are held until the trip unit is reset; a later remote trip sets the external trip code and live currents are sent.
// - Each protection setting is one of eight selector positions.
// - Pick-up settings are per-unit multiples of the rating plug amperes.
// - An automatic trip lights the indicator of the tripping function.
// - Local trip reset clears messages, stored currents, cause indicator and alarm relay.
// - Peak demand, present demand and energy are readable over the network.
package bnsc_pkg;

  // ********************
  // Timing
  // ********************
  localparam int CLK_HZ = 25_000_000;
  localparam int CARRIER_HZ = 115_200;
  localparam int MAX_BIT_RATE = 1200;
  localparam int COIL_MS = 10;
  localparam int HALF_CAR = CLK_HZ / (2 * CARRIER_HZ);
  localparam int BIT_CYC = (CLK_HZ + MAX_BIT_RATE - 1) / MAX_BIT_RATE;
  localparam int COIL_CYC = CLK_HZ / 1000 * COIL_MS;
  localparam int CD_WIN = 4 * HALF_CAR;

  // ********************
  // Frame layout and codes
  // ********************
  localparam int FRAME_W = 32;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [3:0] CMD_POLL = 4'h1;
  localparam logic [3:0] CMD_TRIP = 4'h2;
  localparam logic [3:0] CMD_CLOSE = 4'h3;
  localparam logic [3:0] MSG_STATUS = 4'h0;
  localparam logic [3:0] MSG_CAUSE = 4'h1;
  localparam logic [3:0] MSG_IA = 4'h2;
  localparam logic [3:0] MSG_IB = 4'h3;
  localparam logic [3:0] MSG_IC = 4'h4;
  localparam logic [3:0] MSG_IG = 4'h5;
  localparam logic [3:0] MSG_PEAK = 4'h6;
  localparam logic [3:0] MSG_PRESENT = 4'h7;
  localparam logic [3:0] MSG_ENERGY = 4'h8;
  localparam logic [3:0] MSG_PICKUP = 4'h9;
  localparam logic [3:0] CAUSE_NONE = 4'h0;
  localparam logic [3:0] CAUSE_LONG_DELAY = 4'h1;
  localparam logic [3:0] SHORT_DELAY_TRIP_CODE = 4'h2;
  localparam logic [3:0] CAUSE_INSTANT = 4'h3;
  localparam logic [3:0] CAUSE_GROUND = 4'h4;
  localparam logic [3:0] EXTERNAL_TRIP_CODE = 4'h5;

  // Long-delay pick-up multiples in sixteenths of the plug rating, one per position.
  localparam logic [7:0][4:0] PICKUP_16THS = {5'h10, 5'h0e, 5'h0d, 5'h0c, 5'h0b, 5'h0a, 5'h09, 5'h08};

  typedef enum logic [1:0] {BKR_OPEN = 2'h0, BKR_CLOSED = 2'h1, BKR_TRIPPED = 2'h2} bnsc_bkr_e;
  typedef enum logic [1:0] {FN_LONG = 2'h0, FN_SHORT = 2'h1, FN_INST = 2'h2, FN_GROUND = 2'h3} bnsc_fn_e;
  typedef enum logic [1:0] {TX_IDLE = 2'h0, TX_START = 2'h1, TX_DATA = 2'h3, TX_STOP = 2'h2} bnsc_tx_e;

  typedef struct packed {
    logic [15:0] value;
    logic [3:0] kind;
    logic [11:0] addr;
  } bnsc_frame_s;

  typedef struct packed {
    logic [15:0] ia;
    logic [15:0] ib;
    logic [15:0] ic;
    logic [15:0] ig;
    logic [15:0] peak;
    logic [15:0] present;
    logic [15:0] energy;
  } bnsc_meter_s;

endpackage

// [tb/bnsc_top_monitor.sv]
/*
  Checker bound to bnsc_top: coil pulses, trip latching, digit windows and line timing.
  Assumes one clock domain on CLK with RST_B asynchronous and active low.
*/
`timescale 1ns/1ps
module bnsc_top_monitor #(
  parameter int BIT_CYC = 20834,
  parameter int COIL_CYC = 250000
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // Pins
  input wire logic [2:0][3:0] ADDR_SW,
  input wire logic [2:0][3:0] ADDR_SHOW,
  input wire logic SPRING_OPT,
  input wire logic TRIP_RESET_B,
  input wire logic PROT_TRIP,
  input wire logic [1:0] PROT_FN,
  // Breaker and panel
  input wire logic TRIP_COIL,
  input wire logic CLOSE_COIL,
  input wire logic TRIP_FREE,
  input wire logic ALARM_RELAY,
  input wire logic [3:0] CAUSE_LED,
  // Shared pair
  input wire logic LINE_I,
  input wire logic LINE_O,
  input wire logic LINE_OE
);
  int coil;
  int quiet;
  int low;
  int tog;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      coil <= 0;
      quiet <= 1000;
      low <= BIT_CYC;
      tog <= 1000;
    end else begin
      coil <= TRIP_COIL ? coil + 1 : 0;
      quiet <= $changed(LINE_I) ? 0 : (quiet < 1000 ? quiet + 1 : quiet);
      low <= LINE_OE ? 0 : (low < BIT_CYC ? low + 1 : low);
      tog <= $changed(LINE_O) ? 0 : (tog < 1000 ? tog + 1 : tog);
    end
  end
  function automatic logic [3:0] clampd(input logic [3:0] d);
    return (d > bnsc_pkg::DIGIT_MAX) ? bnsc_pkg::DIGIT_MAX : d;
  endfunction
  sequence sw_still;
    $stable(ADDR_SW) [*4];
  endsequence
  sequence prot_fire;
    PROT_TRIP ##1 1'b1;
  endsequence
  a_show_digits: assert property (sw_still |-> ADDR_SHOW[0] == clampd(ADDR_SW[0])
    && ADDR_SHOW[1] == clampd(ADDR_SW[1]) && ADDR_SHOW[2] == clampd(ADDR_SW[2]))
    else $error("digit window does not follow its selector");
  a_prot_coil: assert property (prot_fire |-> TRIP_COIL && TRIP_FREE && ALARM_RELAY)
    else $error("protection trip not latched");
  a_prot_led: assert property (prot_fire |-> CAUSE_LED[$past(PROT_FN)])
    else $error("indicator of tripping function is dark");
  a_coil_width: assert property ($fell(TRIP_COIL) |-> coil == COIL_CYC)
    else $error("trip coil pulse has the wrong length");
  a_free_hold: assert property ($fell(TRIP_FREE) || $fell(ALARM_RELAY) |->
    !$past(TRIP_RESET_B, 2) || !$past(TRIP_RESET_B, 3) || !$past(TRIP_RESET_B, 4) || !$past(TRIP_RESET_B, 5))
    else $error("trip state cleared without a reset press");
  a_close_spring: assert property ($rose(CLOSE_COIL) |-> $past(SPRING_OPT, 4))
    else $error("close coil driven without the spring option");
  a_tx_quiet: assert property ($rose(LINE_OE) |-> quiet >= 400)
    else $error("transmission started over a received burst");
  a_stop_bit: assert property ($rose(LINE_OE) |-> low >= BIT_CYC - 1)
    else $error("frames spaced closer than one bit");
  a_carrier_rate: assert property ($fell(LINE_O) |-> tog <= bnsc_pkg::HALF_CAR)
    else $error("carrier half period too long");
endmodule

bind bnsc_top bnsc_top_monitor #(.BIT_CYC(BIT_CYC), .COIL_CYC(COIL_CYC)) bnsc_top_monitor_i (
  .CLK(CLK), .RST_B(RST_B), .ADDR_SW(ADDR_SW), .ADDR_SHOW(ADDR_SHOW), .SPRING_OPT(SPRING_OPT),
  .TRIP_RESET_B(TRIP_RESET_B), .PROT_TRIP(PROT_TRIP), .PROT_FN(PROT_FN), .TRIP_COIL(TRIP_COIL),
  .CLOSE_COIL(CLOSE_COIL), .TRIP_FREE(TRIP_FREE), .ALARM_RELAY(ALARM_RELAY), .CAUSE_LED(CAUSE_LED),
  .LINE_I(LINE_I), .LINE_O(LINE_O), .LINE_OE(LINE_OE)
);

// [tb/bnsc_master_model.sv]
/*
  Remote master on the shared pair: keys carrier frames and decodes the station's frames.
  Assumes the station holds LINE_OE high for a whole frame and low for its stop bit.
*/
`timescale 1ns/1ps
module bnsc_master_model #(
  parameter int BIT_CYC = 896
) (
  // Clock and line
  input wire logic clk,
  input wire logic line_o,
  input wire logic line_oe,
  output logic line_i
);
  logic key;
  assign key = line_o & line_oe;
  initial line_i = 1'b0;
  // A one bit is carrier toggling at the carrier rate; a zero leaves the line still.
  task automatic burst(input logic b);
    for (int i = 0; i < BIT_CYC; i++) begin
      @(negedge clk);
      if (b && (i % bnsc_pkg::HALF_CAR == 0)) line_i = ~line_i;
    end
  endtask
  task automatic send(input logic [31:0] f);
    if (line_oe) @(negedge line_oe);
    repeat (100) @(negedge clk);
    burst(1'b1);
    for (int i = 0; i < 32; i++) burst(f[i]);
    burst(1'b0);
  endtask
  task automatic recv(output logic [31:0] f);
    int q;
    int n;
    logic k;
    q = 0;
    while (q < BIT_CYC / 2) begin
      @(posedge clk);
      q = line_oe ? 0 : q + 1;
    end
    @(posedge line_oe);
    for (int i = 0; i < 33; i++) begin
      n = 0;
      repeat (BIT_CYC) begin
        k = key;
        @(posedge clk);
        n += int'(key != k);
      end
      if (i > 0) f[i - 1] = (n >= 2);
    end
  endtask
endmodule

// [tb/test_breaker_network_status_command.sv]
/*
  Self-checking bench: digit windows, local and remote trips, reset press and remote close.
  Assumes the master model on the pair and a behavioural breaker driven by the coils.
*/
`timescale 1ns/1ps
module test_breaker_network_status_command;
  localparam int BITS = 756;
  localparam int COILS = 20;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic [2:0][3:0] ADDR_SW = '0;
  logic [2:0][3:0] ADDR_SHOW;
  logic BKR_CLOSED = 1'b1;
  logic SPRING_OPT = 1'b1;
  logic TRIP_RESET_B = 1'b1;
  logic [2:0] LD_SEL = 3'h0;
  logic [15:0] PLUG_AMPS = 16'h0;
  logic PROT_TRIP = 1'b0;
  logic [1:0] PROT_FN = 2'h0;
  bnsc_pkg::bnsc_meter_s METER = '0;
  logic TRIP_COIL, CLOSE_COIL, TRIP_FREE, ALARM_RELAY, LINE_I, LINE_O, LINE_OE;
  logic [3:0] CAUSE_LED;
  logic [31:0] seed = 32'h19b4;
  logic [31:0] f;
  int fail_count = 0;
  int compares = 0;
  int trip_cyc = 0;
  int close_cyc = 0;
  always #20 CLK = ~CLK;
  bnsc_top #(.BIT_CYC(BITS), .COIL_CYC(COILS)) bnsc_top_i (
    .CLK(CLK), .RST_B(RST_B), .ADDR_SW(ADDR_SW), .ADDR_SHOW(ADDR_SHOW), .BKR_CLOSED(BKR_CLOSED),
    .SPRING_OPT(SPRING_OPT), .TRIP_RESET_B(TRIP_RESET_B), .LD_SEL(LD_SEL), .PLUG_AMPS(PLUG_AMPS),
    .PROT_TRIP(PROT_TRIP), .PROT_FN(PROT_FN), .METER(METER), .TRIP_COIL(TRIP_COIL),
    .CLOSE_COIL(CLOSE_COIL), .TRIP_FREE(TRIP_FREE), .ALARM_RELAY(ALARM_RELAY),
    .CAUSE_LED(CAUSE_LED), .LINE_I(LINE_I), .LINE_O(LINE_O), .LINE_OE(LINE_OE));
  bnsc_master_model #(.BIT_CYC(BITS)) bnsc_master_model_i (
    .clk(CLK), .line_o(LINE_O), .line_oe(LINE_OE), .line_i(LINE_I));
  // Breaker mechanism: coils move the contact and the cycles each coil is energised are counted.
  always @(negedge CLK) begin
    if (TRIP_COIL) begin
      trip_cyc++;
      BKR_CLOSED = 1'b0;
    end
    if (CLOSE_COIL) begin
      close_cyc++;
      BKR_CLOSED = 1'b1;
    end
  end
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic [3:0] clampd(input logic [3:0] d);
    return (d > 4'h9) ? 4'h9 : d;
  endfunction
  function logic [31:0] frame(input logic [3:0] kind, input logic [15:0] value);
    return {value, kind, ADDR_SW};
  endfunction
  function logic [15:0] status(input logic [3:0] c);
    return {8'h00, 2'b11, c, 2'h2};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wrap_up();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (150000) @(posedge CLK);
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (4) @(negedge CLK);
    RST_B = 1'b1;
    for (int i = 0; i < 6; i++) begin
      ADDR_SW = (i == 0) ? 12'hfa9 : 12'(rnd());
      repeat (5) @(negedge CLK);
      for (int d = 0; d < 3; d++) chk(32'(ADDR_SHOW[d]), 32'(clampd(ADDR_SW[d])));
    end
    ADDR_SW = {4'(rnd() % 10), 4'(rnd() % 10), 4'(rnd() % 10)};
    METER = 112'({rnd(), rnd(), rnd(), rnd()});
    PLUG_AMPS = 16'(rnd());
    LD_SEL = 3'(rnd());
    PROT_FN = 2'h1;
    PROT_TRIP = 1'b1;
    @(negedge CLK);
    PROT_TRIP = 1'b0;
    chk(32'({TRIP_FREE, ALARM_RELAY, CAUSE_LED}), 32'h32);
    bnsc_master_model_i.recv(f);
    chk(f, frame(bnsc_pkg::MSG_CAUSE, 16'(bnsc_pkg::SHORT_DELAY_TRIP_CODE)));
    chk(trip_cyc, COILS);
    chk(32'({TRIP_FREE, ALARM_RELAY, CAUSE_LED}), 32'h32);
    TRIP_RESET_B = 1'b0;
    repeat (6) @(negedge CLK);
    TRIP_RESET_B = 1'b1;
    chk(32'({TRIP_FREE, ALARM_RELAY, CAUSE_LED}), 32'h0);
    trip_cyc = 0;
    // The answer follows the command at once, so listening starts before the command is sent.
    fork
      bnsc_master_model_i.send(frame(bnsc_pkg::CMD_TRIP, 16'h0));
      bnsc_master_model_i.recv(f);
    join
    chk(trip_cyc, COILS);
    chk(32'({TRIP_FREE, ALARM_RELAY}), 32'h2);
    chk(f, frame(bnsc_pkg::MSG_STATUS, status(bnsc_pkg::EXTERNAL_TRIP_CODE)));
    bnsc_master_model_i.send(frame(bnsc_pkg::CMD_CLOSE, 16'h0));
    chk(close_cyc, COILS);
    chk(32'(BKR_CLOSED), 32'h1);
    wrap_up();
  end
endmodule
